// ### design/spi_read_path.sv
// serial slave read path: status byte, register streaming, read checksum
// ==========================================================
// Summary of operation
// - command bit zero set means read selected register
// - chip select rising aborts the read at once
// - register shift length depends on its address
// - type 11 advances pointer after every register
// - incremental pointer wraps from 0xf to 0x0
// - type 01 repeats one register, new command otherwise
// - value captured at first rise, updates held off
// - result double buffered, fresh value each pass while the fifo holds one, else the last value repeats
// - mode 0,0: new msb follows data ready
// - mode 1,1: sdo holds previous lsb
// - enable bit appends checksum, none when off
// - checksum is crc16 with polynomial 0x8005
// - static read: checksum after every register
// - incremental read: checksum only after 0xf
// - first checksum covers status; later only new bits
// - format bit picks 16 or 32 bit field
// - wrong chip address: sdo released, command ignored
module spi_read_path #(
  parameter int                RESULT_W  = 16,
  parameter int                FIFO_DEPTH = 8,
  parameter logic [1:0]        CHIP_ADDR = 2'h1
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_sck,
  input  wire logic                i_cs_n,
  input  wire logic                i_sdi,
  output logic                     o_sdo,
  output logic                     o_sdo_oe_n,
  input  wire logic                i_crc_enable,
  input  wire logic                i_crc_format32,
  input  wire logic [2:0]          i_status_flags,
  output logic                     o_status_clear,
  output logic [3:0]               o_reg_addr,
  input  wire logic [31:0]         i_reg_data,
  output logic                     o_reg_hold,
  input  wire logic                i_result_valid,
  input  wire logic [RESULT_W-1:0] i_result_data,
  output logic                     o_result_ready
);

  initial begin
    if (RESULT_W < 1 || RESULT_W > spi_rd_pkg::WORD_W)
      $error("spi_read_path: RESULT_W must be 1..32");
    if (int'(spi_rd_pkg::REG_BITS[0]) != RESULT_W)
      $error("spi_read_path: RESULT_W must match result register width");
  end

  // ==========================================================
  // pin synchronisers and edge detection
  logic [2:0] sck_q;
  logic [2:0] cs_q;
  logic [1:0] sdi_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sck_q <= 3'h0;
      cs_q  <= 3'h7;
      sdi_q <= 2'h0;
    end else begin
      sck_q <= {sck_q[1:0], i_sck};
      cs_q  <= {cs_q[1:0], i_cs_n};
      sdi_q <= {sdi_q[0], i_sdi};
    end
  end

  wire sck_rise = sck_q[1] & ~sck_q[2];
  wire sck_fall = ~sck_q[1] & sck_q[2];
  wire cs_fall  = ~cs_q[1] & cs_q[2];
  wire cs_low   = ~cs_q[1];
  wire sdi      = sdi_q[1];

  // ==========================================================
  // functions
  function automatic logic [spi_rd_pkg::CRC_W-1:0] crc_step(
    input logic [spi_rd_pkg::CRC_W-1:0] crc,
    input logic                         bit_in
  );
    logic fb;
    fb = crc[spi_rd_pkg::CRC_W-1] ^ bit_in;
    crc_step = {crc[spi_rd_pkg::CRC_W-2:0], 1'b0} ^ (fb ? spi_rd_pkg::CRC_POLY : '0);
  endfunction

  function automatic logic [spi_rd_pkg::WORD_W-1:0] left_align(
    input logic [spi_rd_pkg::WORD_W-1:0] value,
    input logic [spi_rd_pkg::BITS_W-1:0] bits
  );
    left_align = value << (7'(spi_rd_pkg::WORD_W) - 7'(bits));
  endfunction

  // ==========================================================
  // state
  spi_rd_pkg::phase_t    phase_q;
  spi_rd_pkg::read_cmd_t cmd_q;
  logic [spi_rd_pkg::CMD_W-1:0]  cmd_sh_q;
  logic [spi_rd_pkg::BITS_W-1:0] cnt_q;
  logic [spi_rd_pkg::WORD_W-1:0] sh_q;
  logic [spi_rd_pkg::CRC_W-1:0]  crc_q;
  logic [RESULT_W-1:0]           result_q;
  logic                          result_fresh_q;
  spi_rd_pkg::crc_cfg_t          cfg;

  assign cfg = '{crc_enable: i_crc_enable, crc_format32: i_crc_format32};

  // ==========================================================
  // decode
  wire [spi_rd_pkg::CMD_W-1:0] cmd_full = {cmd_sh_q[spi_rd_pkg::CMD_W-2:0], sdi};
  wire [1:0] dev_bits = {cmd_sh_q[0], sdi};
  wire addr_ok  = (dev_bits == CHIP_ADDR);
  wire is_read  = cmd_sh_q[spi_rd_pkg::CMD_READ_BIT];
  // decoded from the full byte, valid at the eighth rise where it is captured
  wire is_incr  = (cmd_full[spi_rd_pkg::CMD_TYPE_LSB +: 2] == spi_rd_pkg::TYPE_INCR);
  wire [spi_rd_pkg::ADDR_W-1:0] cmd_addr = cmd_full[spi_rd_pkg::CMD_ADDR_LSB +: 4];

  wire in_data  = (phase_q == spi_rd_pkg::ST_DATA);
  wire at_start = in_data & (cnt_q == '0);
  wire on_result = (cmd_q.addr == spi_rd_pkg::ADDR_RESULT);

  wire [spi_rd_pkg::BITS_W-1:0] data_bits = spi_rd_pkg::REG_BITS[cmd_q.addr];
  wire [spi_rd_pkg::BITS_W-1:0] crc_bits  = cfg.crc_format32 ?
                                            spi_rd_pkg::CRC_BITS_LONG :
                                            spi_rd_pkg::CRC_BITS_SHORT;
  wire [spi_rd_pkg::BITS_W-1:0] unit_bits =
    (phase_q == spi_rd_pkg::ST_STATUS) ? spi_rd_pkg::BITS_W'(spi_rd_pkg::STAT_W) :
    in_data ? data_bits : crc_bits;

  wire [spi_rd_pkg::WORD_W-1:0] src_val = on_result ?
                                          spi_rd_pkg::WORD_W'(result_q) : i_reg_data;
  // live value until the first rise, so a new result moves the idle msb
  wire [spi_rd_pkg::WORD_W-1:0] live_aligned = left_align(src_val, data_bits);
  wire bit_now = at_start ? live_aligned[spi_rd_pkg::WORD_W-1] :
                            sh_q[spi_rd_pkg::WORD_W-1];
  wire unit_end = sck_fall & (cnt_q == unit_bits);
  // a checksum follows every pass in static mode, only after 0xf when incrementing
  wire crc_due = cfg.crc_enable &
                 (~cmd_q.incr | (cmd_q.addr == spi_rd_pkg::ADDR_LAST));
  wire [7:0] stat_vec = {2'h0, CHIP_ADDR, ~CHIP_ADDR[0], i_status_flags};
  wire [spi_rd_pkg::ADDR_W-1:0] next_addr = cmd_q.incr ?
                                            cmd_q.addr + 4'h1 : cmd_q.addr;

  // result buffer refills only while no result word is being shifted
  wire result_busy = in_data & on_result & (cnt_q != '0);
  wire fifo_valid;
  wire [RESULT_W-1:0] fifo_data;
  // one buffered result per pass: the next waits until this one was shifted
  wire take_result = fifo_valid & ~result_busy & ~result_fresh_q;
  wire result_start = at_start & on_result & sck_rise;

  // ==========================================================
  // conversion result buffer
  result_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_result_valid),
    .o_in_ready  (o_result_ready),
    .i_in_data   (i_result_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (take_result),
    .o_out_data  (fifo_data)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst)
      result_q <= '0;
    else if (take_result)
      result_q <= fifo_data;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst)
      result_fresh_q <= 1'b0;
    else if (take_result)
      result_fresh_q <= 1'b1;
    else if (result_start)
      result_fresh_q <= 1'b0;
  end

  // ==========================================================
  // phase sequencing
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase_q <= spi_rd_pkg::ST_IDLE;
      cmd_q   <= '0;
      cnt_q   <= '0;
    end else if (!cs_low) begin
      phase_q <= spi_rd_pkg::ST_IDLE;
      cnt_q   <= '0;
    end else if (cs_fall) begin
      phase_q <= spi_rd_pkg::ST_STATUS;
      cnt_q   <= '0;
    end else begin
      case (phase_q)
        spi_rd_pkg::ST_STATUS: begin
          if (sck_rise) begin
            cnt_q <= cnt_q + 6'h1;
            if (cnt_q == 6'(spi_rd_pkg::ADDR_ACK_RISE - 1) && !addr_ok)
              phase_q <= spi_rd_pkg::ST_IGNORE;
            if (cnt_q == 6'(spi_rd_pkg::CMD_W - 1))
              cmd_q <= '{addr: cmd_addr, incr: is_incr};
          end else if (unit_end) begin
            cnt_q   <= '0;
            phase_q <= is_read ? spi_rd_pkg::ST_DATA : spi_rd_pkg::ST_IGNORE;
          end
        end
        spi_rd_pkg::ST_DATA: begin
          if (sck_rise) begin
            cnt_q <= cnt_q + 6'h1;
          end else if (unit_end) begin
            cnt_q      <= '0;
            cmd_q.addr <= next_addr;
            if (crc_due)
              phase_q <= spi_rd_pkg::ST_CRC;
          end
        end
        spi_rd_pkg::ST_CRC: begin
          if (sck_rise) begin
            cnt_q <= cnt_q + 6'h1;
          end else if (unit_end) begin
            cnt_q   <= '0;
            phase_q <= spi_rd_pkg::ST_DATA;
          end
        end
        spi_rd_pkg::ST_IGNORE: phase_q <= spi_rd_pkg::ST_IGNORE;
        default:               phase_q <= spi_rd_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // command capture and output shifter
  always_ff @(posedge i_clk) begin
    if (i_rst)
      cmd_sh_q <= '0;
    else if (phase_q == spi_rd_pkg::ST_STATUS && sck_rise)
      cmd_sh_q <= cmd_full;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || cs_fall || !cs_low) begin
      sh_q <= '0;
    end else if (at_start) begin
      sh_q <= live_aligned;
    end else if (phase_q == spi_rd_pkg::ST_STATUS && sck_rise &&
                 cnt_q == 6'(spi_rd_pkg::ADDR_ACK_RISE - 1)) begin
      // flags latched once the address is seen
      // top bit is the one already shown; the next fall brings the address bits
      sh_q <= {stat_vec[6:0], 25'h0};
    end else if (in_data && unit_end && crc_due) begin
      sh_q <= {crc_q, 16'h0};
    end else if (sck_fall && !unit_end) begin
      sh_q <= {sh_q[spi_rd_pkg::WORD_W-2:0], 1'b0};
    end
  end

  // ==========================================================
  // read checksum, msb first over the transmitted bits
  always_ff @(posedge i_clk) begin
    if (i_rst || cs_fall) begin
      crc_q <= '0;
    end else if (in_data && unit_end && crc_due) begin
      crc_q <= '0;
    end else if (sck_rise && cs_low &&
                 (phase_q == spi_rd_pkg::ST_STATUS || in_data)) begin
      crc_q <= crc_step(crc_q, bit_now);
    end
  end

  // ==========================================================
  // registered outputs
  wire driving = cs_low & (phase_q == spi_rd_pkg::ST_STATUS || in_data ||
                           phase_q == spi_rd_pkg::ST_CRC);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sdo          <= 1'b0;
      o_sdo_oe_n     <= 1'b1;
      o_status_clear <= 1'b0;
      o_reg_addr     <= '0;
      o_reg_hold     <= 1'b0;
    end else begin
      // no shift between words, so mode 1,1 keeps the last lsb
      o_sdo          <= driving & bit_now;
      o_sdo_oe_n     <= ~driving | cs_fall;
      o_status_clear <= (phase_q == spi_rd_pkg::ST_STATUS) & unit_end & cs_low;
      o_reg_addr     <= cmd_q.addr;
      o_reg_hold     <= in_data & (cnt_q != '0) & cs_low;
    end
  end

endmodule

// ### common/spi_rd_pkg.sv
// shared constants and carriers for the serial read path
package spi_rd_pkg;

  // ==========================================================
  // command byte layout
  localparam int CMD_W          = 8;
  localparam int CMD_READ_BIT   = 0;
  localparam int CMD_TYPE_LSB   = 0;
  localparam int CMD_ADDR_LSB   = 2;
  localparam int CMD_DEV_LSB    = 6;
  localparam logic [1:0] TYPE_STATIC = 2'h1;
  localparam logic [1:0] TYPE_INCR   = 2'h3;

  // ==========================================================
  // register map geometry
  localparam int ADDR_W   = 4;
  localparam int WORD_W   = 32;
  localparam int BITS_W   = 6;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_LAST   = 4'hf;
  // shifted width of each register, index is the address
  localparam logic [BITS_W-1:0] REG_BITS [16] = '{
    6'h10, 6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h18,
    6'h18, 6'h18, 6'h18, 6'h18, 6'h18, 6'h08, 6'h10, 6'h10};

  // ==========================================================
  // status byte and checksum
  localparam int STAT_W  = 8;
  localparam int STAT_FLAGS_W = 3;
  localparam int ADDR_ACK_RISE = 2;
  localparam int CRC_W   = 16;
  localparam logic [CRC_W-1:0] CRC_POLY = 16'h8005;
  localparam logic [BITS_W-1:0] CRC_BITS_SHORT = 6'h10;
  localparam logic [BITS_W-1:0] CRC_BITS_LONG  = 6'h20;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              incr;
  } read_cmd_t;

  typedef struct packed {
    logic crc_enable;
    logic crc_format32;
  } crc_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_STATUS = 3'h1,
    ST_DATA   = 3'h3,
    ST_CRC    = 3'h2,
    ST_IGNORE = 3'h6
  } phase_t;

endpackage

// ### design/result_fifo.sv
// small first-in first-out buffer for conversion results
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1)
      $error("result_fifo: DEPTH must be a power of two >= 2");
  end

  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [PTR_W:0]   count_q;
  logic [PTR_W:0]   count_d;
  logic             full_q;
  logic             empty_q;

  wire push = i_in_valid & ~full_q;
  wire pop  = i_out_ready & ~empty_q;

  assign count_d     = count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
  assign o_in_ready  = ~full_q;
  assign o_out_valid = ~empty_q;
  assign o_out_data  = mem[rd_q];

  always_ff @(posedge i_clk) begin
    if (push)
      mem[wr_q] <= i_in_data;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wr_q    <= wr_q + PTR_W'(push);
      rd_q    <= rd_q + PTR_W'(pop);
      count_q <= count_d;
      full_q  <= (count_d == (PTR_W+1)'(DEPTH));
      empty_q <= (count_d == '0);
    end
  end

endmodule

// ### testbench/spi_read_path_assertions.sv
// port level checks for the serial read path
module spi_read_path_assertions (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_sck,
  input wire logic       i_cs_n,
  input wire logic       o_sdo,
  input wire logic       o_sdo_oe_n,
  input wire logic       o_status_clear,
  input wire logic [3:0] o_reg_addr,
  input wire logic       o_reg_hold
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // steps
  // 8 cycles covers sync flops plus the output register
  sequence s_cs_idle;
    i_cs_n [*8];
  endsequence
  sequence s_sdo_moved;
    !o_sdo_oe_n && $past(!o_sdo_oe_n) && (o_sdo != $past(o_sdo));
  endsequence
  // ==========================================================
  // checks
  AST_ABORT_RELEASE: assert property (s_cs_idle |-> o_sdo_oe_n)
    else $error("sdo still driven with chip select high");
  AST_HOLD_IDLE: assert property (s_cs_idle |-> !o_reg_hold)
    else $error("register hold stuck outside a frame");
  AST_RELEASED_LOW: assert property (o_sdo_oe_n |-> !o_sdo)
    else $error("sdo not parked low while released");
  AST_SDO_AFTER_FALL: assert property (s_sdo_moved |-> !$past(i_sck, 2))
    else $error("sdo moved while serial clock high");
  AST_HOLD_AFTER_RISE: assert property ($rose(o_reg_hold) |-> $past(i_sck, 2))
    else $error("word captured without a serial clock rise");
  AST_HOLD_BOUNDED: assert property ($rose(o_reg_hold) |-> ##[1:420] !o_reg_hold)
    else $error("word longer than 32 bits");
  AST_ADDR_STEADY: assert property (o_reg_hold && $past(o_reg_hold) |-> $stable(o_reg_addr))
    else $error("address moved mid word");
  AST_CLEAR_MATCHED: assert property (o_status_clear |-> $past(!o_sdo_oe_n, 2))
    else $error("status cleared without address match");
endmodule

// ### testbench/spi_host_model.sv
// behavioural serial host that clocks frames and collects sdo
module spi_host_model (
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [511:0] rx, drv;
  logic         last;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    last = 1'b0;
  end
  // ==========================================================
  // one frame of n bits; outside frames sck only moves once, to its idle level m11, before chip select falls
  task automatic xfer(input logic [7:0] cmd, input int n, input logic m11, input int gap);
    rx = '0;
    drv = '0;
    #1 o_sck = m11;
    #24 o_cs_n = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      o_sck = 1'b0;
      o_sdi = (i < 8) ? cmd[7-i] : i[0];
      #24 o_sck = 1'b1;
      // a released line floats: show the inverse of the last level
      last = i_sdo_oe_n ? ~last : i_sdo;
      rx = {rx[510:0], last};
      drv = {drv[510:0], ~i_sdo_oe_n};
      #24;
      if (i % 8 == 7) begin
        if (!m11) o_sck = 1'b0;
        #(gap);
      end
    end
    if (!m11) o_sck = 1'b0;
    #24 o_cs_n = 1'b1;
  endtask
endmodule

// ### testbench/spi_read_path_bench.sv
// self-checking bench for the serial read path
module spi_read_path_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] CA = 2'h1; // arbitrary chip address
  logic         i_clk, i_rst, sck, cs_n, sdi, sdo, sdo_oe_n, crc_en, crc32;
  logic         status_clear, reg_hold, res_valid, res_ready, ok;
  logic [2:0]   flags;
  logic [3:0]   reg_addr;
  logic [31:0]  reg_data;
  logic [15:0]  res_data, crc_q;
  logic [511:0] exp_q;
  int           nb_q, fails, checks, n;

  spi_read_path #(.RESULT_W(16), .FIFO_DEPTH(8), .CHIP_ADDR(CA)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .i_crc_enable(crc_en),
    .i_crc_format32(crc32), .i_status_flags(flags), .o_status_clear(status_clear),
    .o_reg_addr(reg_addr), .i_reg_data(reg_data), .o_reg_hold(reg_hold),
    .i_result_valid(res_valid), .i_result_data(res_data), .o_result_ready(res_ready));
  spi_host_model u_host (.o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo),
    .i_sdo_oe_n(sdo_oe_n));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] regv(input logic [3:0] a);
    return {a, 4'h6, a, 4'h3, ~a, 4'hc, a, 4'h1};
  endfunction
  function automatic logic [31:0] resv(input int k);
    return {16'h0, 16'h1357 ^ {4{k[3:0]}}};
  endfunction
  // device side: map follows the address, flags clear once reported
  always @(posedge i_clk) begin
    reg_data <= regv(reg_addr);
    if (status_clear) flags <= 3'h0;
  end
  task automatic check(input logic [511:0] seen, input logic [511:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic start();
    exp_q = '0;
    crc_q = 16'h0;
    nb_q = 0;
  endtask
  // expected bits msb first, running crc over them
  task automatic add(input logic [31:0] v, input int w);
    for (int i = w - 1; i >= 0; i--) begin
      exp_q = {exp_q[510:0], v[i]};
      crc_q = {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ v[i]) ? 16'h8005 : 16'h0000);
      nb_q++;
    end
  endtask
  task automatic add_crc(input logic f32);
    logic [15:0] c;
    c = crc_q;
    add({16'h0, c}, 16);
    if (f32) add(32'h0, 16);
    crc_q = 16'h0;
  endtask
  task automatic status(input logic [2:0] f);
    add({24'h0, 2'b00, CA, ~CA[0], f}, 8);
  endtask
  task automatic frame(input logic [7:0] cmd, input logic m11, input int gap);
    u_host.xfer(cmd, nb_q, m11, gap);
    check(u_host.rx, exp_q);
    repeat (4) @(posedge i_clk);
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    i_rst = 1'b1;
    crc_en = 1'b1;
    crc32 = 1'b0;
    flags = 3'h5;
    res_valid = 1'b0;
    res_data = 16'h0;
    reg_data = 32'h0;
    fails = 0;
    checks = 0;
    ok = 1'b1;
    n = 0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 16 && ok; k++) begin
      res_data <= 16'(resv(k));
      res_valid <= 1'b1;
      @(posedge i_clk);
      ok = res_ready;
      if (ok) n++;
    end
    res_valid <= 1'b0;
    check(ok, 1'b0);
    check(n >= 8, 1'b1);
    repeat (3) @(posedge i_clk);
    start();
    status(3'h5);
    for (int k = 0; k < n; k++) begin
      add(resv(k), 16);
      add_crc(1'b0);
    end
    frame({CA, 4'h0, 2'h1}, 1'b0, 0);
    $display("test static result stream done");
    crc32 <= 1'b1;
    start();
    status(3'h0);
    add(regv(4'he), spi_rd_pkg::REG_BITS[14]);
    add(regv(4'hf), spi_rd_pkg::REG_BITS[15]);
    add_crc(1'b1);
    add(resv(n - 1), 16);
    add(regv(4'h1), spi_rd_pkg::REG_BITS[1]);
    frame({CA, 4'he, 2'h3}, 1'b1, 0);
    $display("test incremental wrap done");
    crc_en <= 1'b0;
    start();
    status(3'h0);
    repeat (3) add(regv(4'h1), spi_rd_pkg::REG_BITS[1]);
    frame({CA, 4'h1, 2'h1}, 1'b0, 200);
    $display("test static slow host done");
    u_host.xfer({~CA, 4'h1, 2'h1}, 16, 1'b0, 0);
    check(u_host.drv[7:0], 8'h00);
    crc_en <= 1'b1;
    u_host.xfer({CA, 4'h7, 2'h1}, 20, 1'b0, 0);
    repeat (8) @(posedge i_clk);
    check(sdo_oe_n, 1'b1);
    check(reg_hold, 1'b0);
    $display("test refusals done");
    final_report();
  end
endmodule

bind spi_read_path spi_read_path_assertions u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n), .o_sdo(o_sdo),
  .o_sdo_oe_n(o_sdo_oe_n), .o_status_clear(o_status_clear),
  .o_reg_addr(o_reg_addr), .o_reg_hold(o_reg_hold));
